// file: logic/sar_adc_sequencer.sv
// Sequencer, register file and interrupt logic of the 8-bit converter.
// Assumes an external comparator, trial DAC, input mux and sample-hold.
// Overview of operation
// (RULE_01) Successive approximation, result into result register
// (RULE_02) Inputs muxed into one sample-hold
// (RULE_03) Channel field picks the muxed input
// (RULE_04) Software waits settling after channel change
// (RULE_05) Reference field picks supply or external pin
// (RULE_06) Clock codes: 2, 8, 32 periods, RC
// (RULE_07) Conversion lasts nine and a half bit periods
// (RULE_08) Software picks legal clock; RC for sleep
// (RULE_09) Done flag always set; enable gates interrupt
// (RULE_10) Software clears the done flag
// (RULE_11) Interrupt works awake and asleep; wakes device
// (RULE_12) After wake, one instruction, then maybe handler
// (RULE_13) Power bit on; start bit begins conversion
// (RULE_14) Completion clears start, sets flag, loads result
// (RULE_15) Abort keeps result; reacquire after two periods
// (RULE_16) RC clock waits one instruction before start
// (RULE_17) Reset powers off and clears control fields
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module sar_adc_sequencer (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  input  wire logic       cmp_in,
  input  wire logic       rc_osc,
  output logic            irq,
  output logic      [2:0] channel_select,
  output logic            reference_select,
  output logic            converter_power_on,
  output logic            sample_hold,
  output logic      [7:0] dac_code,
  output logic            wake,
  output logic            isr_branch
);

  function automatic logic [4:0] half_len(input logic [1:0] sel);
    case (sel)
      sar_adc_pkg::CLK_DIV2: half_len = sar_adc_pkg::HALF_DIV2;
      sar_adc_pkg::CLK_DIV8: half_len = sar_adc_pkg::HALF_DIV8;
      default:               half_len = sar_adc_pkg::HALF_DIV32;
    endcase
  endfunction

  sar_adc_pkg::ctrl_t       ctrl_q, ctrl_d;
  sar_adc_pkg::conv_state_t st_q, st_d;
  logic [7:0] result_q, result_d;
  logic [7:0] dac_q, dac_d;
  logic [7:0] trial_q, trial_d;
  logic [7:0] rdata_q, rdata_d;
  logic [4:0] half_q, half_d;
  logic [4:0] div_q, div_d;
  logic [2:0] wait_q, wait_d;
  logic [2:0] post_q, post_d;
  logic       ref_q, ref_d;
  logic       flag_q, flag_d;
  logic       en_q, en_d;
  logic       gie_q, gie_d;
  logic       sleep_q, sleep_d;
  logic       irq_q, irq_d;
  logic       hold_q, hold_d;
  logic       wake_q, wake_d;
  logic       isr_q, isr_d;
  logic       cmp_s1, cmp_s2;
  logic       rc_s1, rc_s2, rc_s3;
  logic       tick, finish;
  logic [4:0] k;
  logic [7:0] dac_final;

  always_comb begin
    ctrl_d    = ctrl_q;
    st_d      = st_q;
    result_d  = result_q;
    dac_d     = dac_q;
    trial_d   = trial_q;
    rdata_d   = 8'h00;
    half_d    = half_q;
    div_d     = 5'h00;
    wait_d    = wait_q;
    post_d    = post_q;
    ref_d     = ref_q;
    flag_d    = flag_q;
    en_d      = en_q;
    gie_d     = gie_q;
    sleep_d   = sleep_q;
    wake_d    = 1'b0;
    isr_d     = 1'b0;
    finish    = 1'b0;
    k         = half_q + 5'h01;
    dac_final = dac_q;
    // RULE_06 bit period from clock select
    if (ctrl_q.clk_sel == sar_adc_pkg::CLK_RC) begin
      tick = rc_s2 ^ rc_s3;
    end else begin
      tick = div_q == half_len(ctrl_q.clk_sel) - 5'h01;
    end
    if (wr_en) begin
      case (addr)
        sar_adc_pkg::OFS_CTRL: begin
          ctrl_d = sar_adc_pkg::ctrl_t'(wdata);
          ctrl_d.unused = 1'b0;
          // RULE_13 start ignored unless already powered
          if (!ctrl_q.power) begin
            ctrl_d.go = 1'b0;
          end
        end
        sar_adc_pkg::OFS_CFG: ref_d = wdata[sar_adc_pkg::REF_BIT];
        sar_adc_pkg::OFS_FLAGS: begin
          if (wdata[sar_adc_pkg::DONE_BIT]) begin
            flag_d = 1'b0;
          end
        end
        sar_adc_pkg::OFS_ENABLE: en_d = wdata[sar_adc_pkg::DONE_BIT];
        sar_adc_pkg::OFS_CORE: begin
          gie_d   = wdata[sar_adc_pkg::GIE_BIT];
          sleep_d = wdata[sar_adc_pkg::SLEEP_BIT];
        end
        default: ;
      endcase
    end
    case (st_q)
      sar_adc_pkg::ST_OFF: begin
        if (ctrl_d.power) begin
          st_d = sar_adc_pkg::ST_ACQ;
        end
      end
      sar_adc_pkg::ST_ACQ: begin
        // RULE_13 start bit begins conversion
        if (ctrl_d.go) begin
          half_d  = 5'h00;
          trial_d = 8'h00;
          wait_d  = sar_adc_pkg::INSTR_CLKS;
          // RULE_16 extra instruction on RC
          if (ctrl_d.clk_sel == sar_adc_pkg::CLK_RC) begin
            st_d = sar_adc_pkg::ST_RC_WAIT;
          end else begin
            st_d = sar_adc_pkg::ST_CONV;
          end
        end
      end
      sar_adc_pkg::ST_RC_WAIT: begin
        if (!ctrl_d.go) begin
          st_d   = sar_adc_pkg::ST_ABORT;
          half_d = 5'h00;
        end else if (wait_q == 3'h1) begin
          st_d = sar_adc_pkg::ST_CONV;
        end else begin
          wait_d = wait_q - 3'h1;
        end
      end
      sar_adc_pkg::ST_CONV: begin
        // RULE_15 cleared start aborts, result kept
        if (!ctrl_d.go) begin
          st_d   = sar_adc_pkg::ST_ABORT;
          half_d = 5'h00;
        end else begin
          div_d = tick ? 5'h00 : div_q + 5'h01;
          if (tick) begin
            half_d = k;
            // RULE_01 trial bits from the top down
            if (k == sar_adc_pkg::HALF_FIRST) begin
              dac_d   = 8'h80;
              trial_d = 8'h80;
            end else if (k > sar_adc_pkg::HALF_FIRST && k[0]) begin
              if (!cmp_s2) begin
                dac_final = dac_q & ~trial_q;
              end
              dac_d   = dac_final | (trial_q >> 1);
              trial_d = trial_q >> 1;
            end
            // RULE_07 done after nineteen half periods
            if (k == sar_adc_pkg::HALF_TOTAL) begin
              finish = 1'b1;
              st_d   = sar_adc_pkg::ST_ACQ;
            end
          end
        end
      end
      sar_adc_pkg::ST_ABORT: begin
        ctrl_d.go = 1'b0;
        div_d     = tick ? 5'h00 : div_q + 5'h01;
        // RULE_15 two period delay, then acquire
        if (tick) begin
          half_d = k;
          if (k == sar_adc_pkg::HALF_ABORT) begin
            st_d = sar_adc_pkg::ST_ACQ;
          end
        end
      end
      default: st_d = sar_adc_pkg::ST_OFF;
    endcase
    // RULE_14 completion clears start, flags, loads
    if (finish) begin
      ctrl_d.go = 1'b0;
      result_d  = dac_final;
      // RULE_09 flag set regardless of enable
      flag_d    = 1'b1;
    end
    if (!ctrl_d.power) begin
      st_d      = sar_adc_pkg::ST_OFF;
      ctrl_d.go = 1'b0;
    end
    // RULE_02 hold while converting
    hold_d = st_d == sar_adc_pkg::ST_CONV;
    // RULE_09 enable alone gates the request
    irq_d  = flag_q & en_q;
    // RULE_11 enabled interrupt wakes from sleep
    if (sleep_q && irq_q) begin
      sleep_d = 1'b0;
      wake_d  = 1'b1;
      post_d  = sar_adc_pkg::INSTR_CLKS;
    end else if (post_q != 3'h0) begin
      post_d = post_q - 3'h1;
      // RULE_12 handler only after next instruction
      isr_d  = post_q == 3'h1 && gie_q;
    end
    if (rd_en) begin
      case (addr)
        sar_adc_pkg::OFS_CTRL:   rdata_d = ctrl_q;
        sar_adc_pkg::OFS_CFG:    rdata_d[sar_adc_pkg::REF_BIT] = ref_q;
        sar_adc_pkg::OFS_RESULT: rdata_d = result_q;
        sar_adc_pkg::OFS_FLAGS:  rdata_d[sar_adc_pkg::DONE_BIT] = flag_q;
        sar_adc_pkg::OFS_ENABLE: rdata_d[sar_adc_pkg::DONE_BIT] = en_q;
        sar_adc_pkg::OFS_CORE: begin
          rdata_d[sar_adc_pkg::GIE_BIT]   = gie_q;
          rdata_d[sar_adc_pkg::SLEEP_BIT] = sleep_q;
        end
        default: ;
      endcase
    end
  end

  // RULE_17 reset powers off and clears fields
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q   <= sar_adc_pkg::CTRL_RESET;
      st_q     <= sar_adc_pkg::ST_OFF;
      result_q <= sar_adc_pkg::RESULT_RESET;
      dac_q    <= sar_adc_pkg::DAC_RESET;
      trial_q  <= 8'h00;
      rdata_q  <= 8'h00;
      half_q   <= 5'h00;
      div_q    <= 5'h00;
      wait_q   <= 3'h0;
      post_q   <= 3'h0;
      ref_q    <= 1'b0;
      flag_q   <= 1'b0;
      en_q     <= 1'b0;
      gie_q    <= 1'b0;
      sleep_q  <= 1'b0;
      irq_q    <= 1'b0;
      hold_q   <= 1'b0;
      wake_q   <= 1'b0;
      isr_q    <= 1'b0;
      cmp_s1   <= 1'b0;
      cmp_s2   <= 1'b0;
      rc_s1    <= 1'b0;
      rc_s2    <= 1'b0;
      rc_s3    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      st_q     <= st_d;
      result_q <= result_d;
      dac_q    <= dac_d;
      trial_q  <= trial_d;
      rdata_q  <= rdata_d;
      half_q   <= half_d;
      div_q    <= div_d;
      wait_q   <= wait_d;
      post_q   <= post_d;
      ref_q    <= ref_d;
      flag_q   <= flag_d;
      en_q     <= en_d;
      gie_q    <= gie_d;
      sleep_q  <= sleep_d;
      irq_q    <= irq_d;
      hold_q   <= hold_d;
      wake_q   <= wake_d;
      isr_q    <= isr_d;
      cmp_s1   <= cmp_in;
      cmp_s2   <= cmp_s1;
      rc_s1    <= rc_osc;
      rc_s2    <= rc_s1;
      rc_s3    <= rc_s2;
    end
  end

  assign rdata              = rdata_q;
  assign irq                = irq_q;
  // RULE_03 channel field drives the mux
  assign channel_select     = ctrl_q.chan;
  // RULE_05 reference select to the reference switch
  assign reference_select   = ref_q;
  assign converter_power_on = ctrl_q.power;
  assign sample_hold        = hold_q;
  assign dac_code           = dac_q;
  assign wake               = wake_q;
  assign isr_branch         = isr_q;

  // Cycles spent in conversion, for checking
  logic [8:0] cyc_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cyc_q <= 9'h000;
    end else begin
      cyc_q <= st_q == sar_adc_pkg::ST_CONV ? cyc_q + 9'h001 : 9'h000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_abort_wait;
    (st_q == sar_adc_pkg::ST_ABORT)[*4];
  endsequence
  sequence s_rc_delay;
    (st_q != sar_adc_pkg::ST_CONV)[*4];
  endsequence

  property p_complete;
    finish |=> flag_q && !ctrl_q.go && result_q == $past(dac_final);
  endproperty
  a_complete: assert property (p_complete) // RULE_14
    else $error("completion did not flag and load");

  property p_length;
    finish && ctrl_q.clk_sel != sar_adc_pkg::CLK_RC |->
      cyc_q == 9'(sar_adc_pkg::HALF_TOTAL) * 9'(half_len(ctrl_q.clk_sel))
               - 9'h001;
  endproperty
  a_length: assert property (p_length) // RULE_07
    else $error("conversion length wrong");

  property p_keep;
    st_q == sar_adc_pkg::ST_ABORT |=> $stable(result_q);
  endproperty
  a_keep: assert property (p_keep) // RULE_15
    else $error("result changed on abort");

  property p_abort;
    $rose(st_q == sar_adc_pkg::ST_ABORT) && ctrl_q.power &&
      ctrl_q.clk_sel == sar_adc_pkg::CLK_DIV2 |->
      s_abort_wait ##1 (st_q == sar_adc_pkg::ST_ACQ || !ctrl_q.power);
  endproperty
  a_abort: assert property (p_abort) // RULE_15
    else $error("abort delay wrong");

  property p_rc_wait;
    $rose(st_q == sar_adc_pkg::ST_RC_WAIT) |-> s_rc_delay;
  endproperty
  a_rc_wait: assert property (p_rc_wait) // RULE_16
    else $error("RC start not delayed");

  property p_irq;
    flag_q && en_q |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) // RULE_09
    else $error("enabled flag gave no interrupt");

  property p_no_irq;
    !en_q |=> !irq_q;
  endproperty
  a_no_irq: assert property (p_no_irq) // RULE_09
    else $error("interrupt while disabled");

  property p_wake;
    wake_q |-> ##1 (!isr_q)[*3] ##1 (isr_q == $past(gie_q));
  endproperty
  a_wake: assert property (p_wake) // RULE_12
    else $error("wake sequence wrong");

  property p_off;
    !ctrl_q.power |-> !ctrl_q.go && st_q == sar_adc_pkg::ST_OFF;
  endproperty
  a_off: assert property (p_off) // RULE_13
    else $error("start set while powered off");

endmodule // sar_adc_sequencer

// file: logic/sar_adc_pkg.sv
// Constants and types for the 8-bit successive approximation sequencer.
// Assumes a single 200 MHz clock; the RC oscillator is a separate input, rc_osc.
package sar_adc_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] OFS_CTRL   = 3'h0;
  localparam logic [2:0] OFS_CFG    = 3'h1;
  localparam logic [2:0] OFS_RESULT = 3'h2;
  localparam logic [2:0] OFS_FLAGS  = 3'h3;
  localparam logic [2:0] OFS_ENABLE = 3'h4;
  localparam logic [2:0] OFS_CORE   = 3'h5;

  // Field positions
  localparam int DONE_BIT  = 6;
  localparam int GIE_BIT   = 7;
  localparam int SLEEP_BIT = 0;
  localparam int REF_BIT   = 0;

  // Clock select codes
  localparam logic [1:0] CLK_DIV2  = 2'h0;
  localparam logic [1:0] CLK_DIV8  = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC    = 2'h3;

  // Half bit period in clock cycles per clock select
  localparam logic [4:0] HALF_DIV2  = 5'h01;
  localparam logic [4:0] HALF_DIV8  = 5'h04;
  localparam logic [4:0] HALF_DIV32 = 5'h10;

  // Sequence counts in half bit periods
  localparam logic [4:0] HALF_FIRST  = 5'h03;
  localparam logic [4:0] HALF_TOTAL  = 5'h13;
  localparam logic [4:0] HALF_ABORT  = 5'h04;
  // One instruction cycle in clock cycles
  localparam logic [2:0] INSTR_CLKS  = 3'h4;

  // Reset values
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] DAC_RESET    = 8'h00;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [2:0] chan;
    logic       go;
    logic       unused;
    logic       power;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 8'h00;

  typedef enum {
    ST_OFF, ST_ACQ, ST_RC_WAIT, ST_CONV, ST_ABORT
  } conv_state_t;

endpackage

// file: testbench/sar_far_side.sv
// Far side model: held channel levels, comparator and RC oscillator.
// Assumes the sequencer drives channel, trial code and power outputs.
`timescale 1ns/1ps
module sar_far_side (
  input  wire logic [63:0] levels,
  input  wire logic        clock,
  input  wire logic [2:0]  channel_select,
  input  wire logic        converter_power_on,
  input  wire logic [7:0]  dac_code,
  output logic             cmp_in,
  output logic             rc_osc
);
  logic junk_q;
  // Free running RC source, unrelated phase
  initial begin
    junk_q = 1'b0;
    rc_osc = 1'b0;
    forever #23 rc_osc = ~rc_osc;
  end
  always @(posedge clock) junk_q <= ~junk_q;
  assign cmp_in = converter_power_on ?
                  (levels[channel_select*8 +: 8] >= dac_code) : junk_q;
endmodule // sar_far_side

// file: testbench/sar_adc_sequencer_test.sv
// Self-checking bench for the converter sequencer.
// Assumes the far side model drives comparator and RC oscillator.
`timescale 1ns/1ps
module sar_adc_sequencer_test;
  typedef struct packed {
    logic [1:0] clk;
    logic [2:0] ch;
    logic [9:0] cycles;
  } row_t;
  localparam logic [63:0] LEVELS = 64'h3c81_5aff_0012_a55a;
  // fastest clock only on full scale level
  localparam row_t        ROWS [5] = '{
    '{2'h0, 3'h4, 10'h013}, '{2'h1, 3'h0, 10'h04c},
    '{2'h2, 3'h3, 10'h130}, '{2'h1, 3'h6, 10'h04c},
    '{2'h3, 3'h1, 10'h000}};
  localparam logic [2:0]  CTRL = sar_adc_pkg::OFS_CTRL;
  localparam logic [2:0]  RES  = sar_adc_pkg::OFS_RESULT;
  localparam logic [2:0]  FLG  = sar_adc_pkg::OFS_FLAGS;
  localparam logic [2:0]  ENA  = sar_adc_pkg::OFS_ENABLE;
  localparam logic [2:0]  CORE = sar_adc_pkg::OFS_CORE;
  logic       clock, rstn, wr_en, rd_en, cmp_in, rc_osc, irq;
  logic [2:0] addr, channel_select;
  logic [7:0] wdata, rdata, dac_code, lvl;
  logic       reference_select, converter_power_on, sample_hold;
  logic       wake, isr_branch;
  row_t       r;
  int         n_errors, check_count, cyc, hold_cnt, wake_at, isr_at, i;

  sar_adc_sequencer dut (.clock(clock), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .cmp_in(cmp_in), .rc_osc(rc_osc), .irq(irq),
    .channel_select(channel_select), .reference_select(reference_select),
    .converter_power_on(converter_power_on), .sample_hold(sample_hold),
    .dac_code(dac_code), .wake(wake), .isr_branch(isr_branch));
  sar_far_side far (.levels(LEVELS), .clock(clock),
    .channel_select(channel_select), .converter_power_on(converter_power_on),
    .dac_code(dac_code), .cmp_in(cmp_in), .rc_osc(rc_osc));

  task automatic complete_run;
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] exp,
                       input string name);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    pause(1);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp,
                    input string name);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 check(10'(rdata), 10'(exp), name);
    pause(1);
  endtask
  task automatic run_conv(input logic [7:0] ctrl);
    wr(CTRL, ctrl & 8'hfb);
    pause(8);
    hold_cnt = 0;
    wr(CTRL, ctrl);
    repeat (3000) if (hold_cnt == 0 || sample_hold !== 1'b0) pause(1);
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (sample_hold === 1'b1) hold_cnt <= hold_cnt + 1;
    if (wake === 1'b1) wake_at <= cyc;
    if (isr_branch === 1'b1) isr_at <= cyc;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    rstn = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    n_errors = 0;
    check_count = 0;
    cyc = 0;
    hold_cnt = 0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (i = 0; i < 8; i++) rd(3'(i), 8'h00, "reset value");
    wr(CTRL, 8'h05);
    pause(8);
    check(10'(hold_cnt), 10'h000, "start while off");
    rd(CTRL, 8'h01, "power only");
    wr(sar_adc_pkg::OFS_CFG, 8'h01);
    check(10'(reference_select), 10'h001, "reference pin");
    wr(sar_adc_pkg::OFS_CFG, 8'h00);
    check(10'(reference_select), 10'h000, "reference supply");
    wr(3'h7, 8'hff);
    rd(3'h7, 8'h00, "unmapped");
    for (i = 0; i < 5; i++) begin
      r = ROWS[i];
      lvl = LEVELS[r.ch*8 +: 8];
      run_conv({r.clk, r.ch, 3'h5});
      if (r.cycles != 0) check(10'(hold_cnt), r.cycles, "cycles");
      check(10'(channel_select), 10'(r.ch), "channel");
      check(10'(converter_power_on), 10'h001, "power pin");
      check(10'(dac_code), 10'(lvl), "trial code");
      rd(FLG, 8'h40, "done flag");
      check(10'(irq), 10'h000, "irq disabled");
      rd(CTRL, {r.clk, r.ch, 3'h1}, "start cleared");
      rd(RES, lvl, "result");
      wr(FLG, 8'h40);
      rd(FLG, 8'h00, "flag cleared");
    end
    wr(ENA, 8'h40);
    run_conv(8'h85);
    pause(2);
    check(10'(irq), 10'h001, "irq raised");
    wr(ENA, 8'h00);
    check(10'(irq), 10'h000, "irq masked");
    wr(ENA, 8'h40);
    wr(FLG, 8'h40);
    check(10'(irq), 10'h000, "irq cleared");
    for (i = 0; i < 2; i++) begin
      wake_at = 0;
      isr_at = 0;
      wr(CORE, (i == 1) ? 8'h81 : 8'h01);
      run_conv(8'hc5);
      pause(12);
      check(10'(wake_at != 0), 10'h001, "wake");
      check(10'(isr_at == 0 ? 0 : isr_at - wake_at), 10'(4 * i), "branch");
      rd(CORE, (i == 1) ? 8'h80 : 8'h00, "sleep cleared");
      wr(FLG, 8'h40);
    end
    wr(CTRL, 8'h21);
    pause(8);
    wr(CTRL, 8'h25);
    wr(CTRL, 8'h21);
    pause(80);
    check(10'(sample_hold), 10'h000, "aborted");
    rd(FLG, 8'h00, "no flag on abort");
    rd(RES, 8'h5a, "result kept");
    run_conv(8'ha5);
    rd(RES, 8'hff, "after abort");
    wr(RES, 8'h11);
    rd(RES, 8'hff, "result read only");
    wr(CTRL, 8'ha5);
    pause(20);
    rstn <= 1'b0;
    pause(2);
    check(10'({converter_power_on, sample_hold, channel_select}), 10'h000,
          "reset outputs");
    rstn <= 1'b1;
    pause(1);
    rd(CTRL, 8'h00, "control after reset");
    complete_run();
  end
endmodule // sar_adc_sequencer_test
